// >>> design/bfsl_top.sv
// fault latching, lamp pattern and latest fault registers of the bridge
// What this block does
// R01 - supply drop sets supply_drop_flag, held until clear or reset
// R02 - supply drop writes code 00C8H into latest_fault_code
// R03 - supply drop writes 0FFFH into latest_fault_node
// R04 - latched supply drop fault blinks lamp, toggling every 0.2 s
// R05 - bit transmission halts while supply drop is present
// R06 - transmission restarts by itself once supply drop goes away
// R07 - flag, blinking and registers stay after the drop cause goes
// R08 - clear pulse drops supply flag, lamp off, both registers zeroed
// R09 - simultaneous faults: registers and lamp show the latest one
// R10 - hardware fault codes 012CH/012DH, bad target id 012EH
// R11 - bad value 012FH, generic access failure 0130H, status 0131H
// R12 - duplicated id 0190H, unassigned id 0191H during access
// R13 - generic failure sets access fault flag, others set slave alarm
// R14 - bad target id fault writes 0FFFH as node
// R15 - other access faults write offending slave id as node
// R16 - slave alarm and registers held until clear pulse or reset
// R17 - clear pulse drops access fault flag and zeroes registers
// R18 - access error also sets the access done flag
// R19 - clear acts once on rising edge of request, within one cycle
// R20 - both registers 16 bits, read only, zero after reset
`timescale 1ns/1ps
module bfsl_top
  import bfsl_pkg::*;
#(
  parameter int BLINK_CYC = BFSL_BLINK_CYC
)
(
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic SUPPLY_LOW_IN,
  input wire logic PFAULT_VALID_IN,
  input wire logic [2:0] PFAULT_KIND_IN,
  input wire logic [15:0] PFAULT_NODE_IN,
  input wire logic ACCESS_START_IN,
  input wire logic FAULT_CLEAR_REQUEST_IN,
  input wire logic REG_SEL_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic [15:0] LATEST_FAULT_CODE_OUT,
  output logic [15:0] LATEST_FAULT_NODE_OUT,
  output logic SUPPLY_DROP_FLAG_OUT,
  output logic SLAVE_ALARM_FLAG_OUT,
  output logic PARAM_ACCESS_FAULT_FLAG_OUT,
  output logic PARAM_ACCESS_DONE_FLAG_OUT,
  output logic ALARM_LAMP_OUT,
  output logic TX_ENABLE_OUT
);
  logic clr_prev_reg;
  logic clr_pulse;
  logic drop_prev_reg;
  logic drop_rise;
  logic blink_run_reg;
  logic blink_tick;
  logic lamp_reg;
  logic [15:0] code_next;
  logic [15:0] node_next;
  logic load_regs;

  // map an access fault kind to its code
  function automatic logic [15:0] bfsl_code_of(input logic [2:0] kind);
    case (bfsl_pfault_t'(kind))
      BFSL_PF_HW_A: bfsl_code_of = BFSL_CODE_HW_A;
      BFSL_PF_HW_B: bfsl_code_of = BFSL_CODE_HW_B;
      BFSL_PF_BAD_TARGET: bfsl_code_of = BFSL_CODE_BAD_TARGET;
      BFSL_PF_BAD_VALUE: bfsl_code_of = BFSL_CODE_BAD_VALUE;
      BFSL_PF_ACCESS: bfsl_code_of = BFSL_CODE_ACCESS;
      BFSL_PF_SLAVE_STATUS: bfsl_code_of = BFSL_CODE_SLAVE_STATUS;
      BFSL_PF_DUP_ID: bfsl_code_of = BFSL_CODE_DUP_ID;
      BFSL_PF_NO_ID: bfsl_code_of = BFSL_CODE_NO_ID;
      default: bfsl_code_of = BFSL_CODE_ACCESS;
    endcase
  endfunction : bfsl_code_of

  // R19 edge detect clear
  // holding the request high only clears once, at its rising edge
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      clr_prev_reg <= 1'b0;
      drop_prev_reg <= 1'b0;
    end
    else
    begin
      clr_prev_reg <= FAULT_CLEAR_REQUEST_IN;
      drop_prev_reg <= SUPPLY_LOW_IN;
    end
  end
  assign clr_pulse = FAULT_CLEAR_REQUEST_IN && !clr_prev_reg;
  assign drop_rise = SUPPLY_LOW_IN && !drop_prev_reg;

  // next register contents; supply drop beats an access fault in the same cycle
  always_comb
  begin
    load_regs = 1'b0;
    code_next = LATEST_FAULT_CODE_OUT;
    node_next = LATEST_FAULT_NODE_OUT;
    if (drop_rise)
    begin
      load_regs = 1'b1;
      // R02 drop code
      code_next = BFSL_CODE_SUPPLY_DROP;
      // R03 drop node
      node_next = BFSL_NODE_NONE;
    end
    else if (PFAULT_VALID_IN)
    begin
      load_regs = 1'b1;
      // R10 R11 R12 code select
      code_next = bfsl_code_of(PFAULT_KIND_IN);
      // R14 R15 node select
      node_next = (bfsl_pfault_t'(PFAULT_KIND_IN) == BFSL_PF_BAD_TARGET) ?
        BFSL_NODE_NONE : PFAULT_NODE_IN;
    end
    else if (clr_pulse)
    begin
      // R08 cleared view
      // the read port must see the zeroed pair, not the stale one
      code_next = BFSL_REG_RESET;
      node_next = BFSL_REG_RESET;
    end
  end

  // R09 R16 R17 R20 latest registers
  // a new fault in the clear cycle wins, so it is never lost
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      LATEST_FAULT_CODE_OUT <= BFSL_REG_RESET;
      LATEST_FAULT_NODE_OUT <= BFSL_REG_RESET;
    end
    else if (load_regs)
    begin
      LATEST_FAULT_CODE_OUT <= code_next;
      LATEST_FAULT_NODE_OUT <= node_next;
    end
    else if (clr_pulse)
    begin
      LATEST_FAULT_CODE_OUT <= BFSL_REG_RESET;
      LATEST_FAULT_NODE_OUT <= BFSL_REG_RESET;
    end
  end

  // R01 R07 R08 supply flag
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      SUPPLY_DROP_FLAG_OUT <= 1'b0;
    else if (drop_rise)
      SUPPLY_DROP_FLAG_OUT <= 1'b1;
    else if (clr_pulse)
      SUPPLY_DROP_FLAG_OUT <= 1'b0;
  end

  // R13 R16 R17 access flags
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      SLAVE_ALARM_FLAG_OUT <= 1'b0;
      PARAM_ACCESS_FAULT_FLAG_OUT <= 1'b0;
    end
    else
    begin
      if (PFAULT_VALID_IN && bfsl_pfault_t'(PFAULT_KIND_IN) != BFSL_PF_ACCESS)
        SLAVE_ALARM_FLAG_OUT <= 1'b1;
      else if (clr_pulse)
        SLAVE_ALARM_FLAG_OUT <= 1'b0;
      if (PFAULT_VALID_IN && bfsl_pfault_t'(PFAULT_KIND_IN) == BFSL_PF_ACCESS)
        PARAM_ACCESS_FAULT_FLAG_OUT <= 1'b1;
      else if (clr_pulse)
        PARAM_ACCESS_FAULT_FLAG_OUT <= 1'b0;
    end
  end

  // R18 done flag
  // a new access start drops done; an error report completes it
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      PARAM_ACCESS_DONE_FLAG_OUT <= 1'b0;
    else if (PFAULT_VALID_IN)
      PARAM_ACCESS_DONE_FLAG_OUT <= 1'b1;
    else if (ACCESS_START_IN)
      PARAM_ACCESS_DONE_FLAG_OUT <= 1'b0;
  end

  // R05 R06 transmission gate
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      TX_ENABLE_OUT <= 1'b1;
    else
      TX_ENABLE_OUT <= !SUPPLY_LOW_IN;
  end

  // R04 R09 blink mode
  // blinking belongs to the supply drop; a later access fault shows steady lamp
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      blink_run_reg <= 1'b0;
    else if (drop_rise)
      blink_run_reg <= 1'b1;
    else if (PFAULT_VALID_IN || clr_pulse)
      blink_run_reg <= 1'b0;
  end

  bfsl_blink #(
    .HALF_CYC(BLINK_CYC)
  ) u_blink (
    .clk_in(CLK_IN),
    .srst_in(SRST_IN),
    .run_in(blink_run_reg),
    .toggle_out(blink_tick)
  );

  // R04 R08 lamp drive
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      lamp_reg <= 1'b0;
    else if (drop_rise)
      lamp_reg <= 1'b1;
    else if (PFAULT_VALID_IN)
      lamp_reg <= 1'b1;
    else if (clr_pulse)
      lamp_reg <= 1'b0;
    else if (blink_run_reg && blink_tick)
      lamp_reg <= !lamp_reg;
  end
  assign ALARM_LAMP_OUT = lamp_reg;

  // R20 read port
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      REG_RDATA_OUT <= BFSL_REG_RESET;
    else
      REG_RDATA_OUT <= (REG_SEL_IN == BFSL_IDX_NODE) ? node_next : code_next;
  end

  // assertions
  a_drop_code_node: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // R02 R03
    drop_rise |=> LATEST_FAULT_CODE_OUT == BFSL_CODE_SUPPLY_DROP
      && LATEST_FAULT_NODE_OUT == BFSL_NODE_NONE)
    else $error("supply drop registers wrong");
  a_drop_flag_set: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // R01
    drop_rise |=> SUPPLY_DROP_FLAG_OUT)
    else $error("supply flag not set");
  a_drop_flag_hold: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // R07
    SUPPLY_DROP_FLAG_OUT && !clr_pulse |=> SUPPLY_DROP_FLAG_OUT)
    else $error("supply flag lost");
  a_tx_halt: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // R05
    SUPPLY_LOW_IN |=> !TX_ENABLE_OUT)
    else $error("transmission not halted");
  a_tx_resume: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // R06
    !SUPPLY_LOW_IN |=> TX_ENABLE_OUT)
    else $error("transmission not resumed");
  a_clear_all: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // R08
    clr_pulse && !PFAULT_VALID_IN && !drop_rise |=> !SUPPLY_DROP_FLAG_OUT
      && !ALARM_LAMP_OUT && LATEST_FAULT_CODE_OUT == 16'h0000
      && LATEST_FAULT_NODE_OUT == 16'h0000
      && !SLAVE_ALARM_FLAG_OUT && !PARAM_ACCESS_FAULT_FLAG_OUT)
    else $error("clear incomplete");
  // a held request must leave any latched flag alone
  a_clear_level: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // R19
    FAULT_CLEAR_REQUEST_IN && $past(FAULT_CLEAR_REQUEST_IN)
      && (SUPPLY_DROP_FLAG_OUT || SLAVE_ALARM_FLAG_OUT || PARAM_ACCESS_FAULT_FLAG_OUT)
      |=> SUPPLY_DROP_FLAG_OUT || SLAVE_ALARM_FLAG_OUT || PARAM_ACCESS_FAULT_FLAG_OUT)
    else $error("held request cleared again");
  a_bad_target: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // R14
    PFAULT_VALID_IN && !drop_rise && PFAULT_KIND_IN == 3'h2
      |=> LATEST_FAULT_CODE_OUT == BFSL_CODE_BAD_TARGET
      && LATEST_FAULT_NODE_OUT == BFSL_NODE_NONE && SLAVE_ALARM_FLAG_OUT)
    else $error("bad target report wrong");
  a_access_flag: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // R13 R18
    PFAULT_VALID_IN && !drop_rise && PFAULT_KIND_IN == 3'h4
      |=> PARAM_ACCESS_FAULT_FLAG_OUT && PARAM_ACCESS_DONE_FLAG_OUT
      && LATEST_FAULT_NODE_OUT == $past(PFAULT_NODE_IN))
    else $error("access fault report wrong");
  sequence s_blink_on;
    blink_run_reg && blink_tick && !drop_rise && !PFAULT_VALID_IN && !clr_pulse;
  endsequence
  a_lamp_blink: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // R04
    s_blink_on |=> ALARM_LAMP_OUT != $past(ALARM_LAMP_OUT))
    else $error("lamp did not toggle");
endmodule : bfsl_top

// >>> inc/bfsl_pkg.sv
// constants for the bridge fault status logic
package bfsl_pkg;
  localparam logic [15:0] BFSL_CODE_SUPPLY_DROP = 16'h00C8;
  localparam logic [15:0] BFSL_CODE_HW_A = 16'h012C;
  localparam logic [15:0] BFSL_CODE_HW_B = 16'h012D;
  localparam logic [15:0] BFSL_CODE_BAD_TARGET = 16'h012E;
  localparam logic [15:0] BFSL_CODE_BAD_VALUE = 16'h012F;
  localparam logic [15:0] BFSL_CODE_ACCESS = 16'h0130;
  localparam logic [15:0] BFSL_CODE_SLAVE_STATUS = 16'h0131;
  localparam logic [15:0] BFSL_CODE_DUP_ID = 16'h0190;
  localparam logic [15:0] BFSL_CODE_NO_ID = 16'h0191;
  localparam logic [15:0] BFSL_NODE_NONE = 16'h0FFF;
  localparam logic [15:0] BFSL_REG_RESET = 16'h0000;
  // register indices on the remote register window
  localparam logic BFSL_IDX_CODE = 1'b0;
  localparam logic BFSL_IDX_NODE = 1'b1;
  // lamp timing
  localparam int BFSL_CLK_HZ = 25000000;
  localparam int BFSL_BLINK_MS = 200;
  localparam int BFSL_BLINK_CYC = (BFSL_CLK_HZ / 1000) * BFSL_BLINK_MS;
  // parameter access fault kinds
  typedef enum logic [2:0] {
    BFSL_PF_HW_A,
    BFSL_PF_HW_B,
    BFSL_PF_BAD_TARGET,
    BFSL_PF_BAD_VALUE,
    BFSL_PF_ACCESS,
    BFSL_PF_SLAVE_STATUS,
    BFSL_PF_DUP_ID,
    BFSL_PF_NO_ID
  } bfsl_pfault_t;
endpackage : bfsl_pkg

// >>> design/bfsl_blink.sv
// toggle divider for the alarm lamp
`timescale 1ns/1ps
module bfsl_blink
  import bfsl_pkg::*;
#(
  parameter int HALF_CYC = BFSL_BLINK_CYC
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic run_in,
  output logic toggle_out
);
  logic [31:0] cnt_reg;

  // counter restarts whenever blinking is off so the first toggle is a full interval late
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !run_in)
    begin
      cnt_reg <= 32'h00000000;
      toggle_out <= 1'b0;
    end
    else if (cnt_reg == 32'(HALF_CYC - 1))
    begin
      cnt_reg <= 32'h00000000;
      toggle_out <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 32'h00000001;
      toggle_out <= 1'b0;
    end
  end
endmodule : bfsl_blink

// >>> tb/bfsl_ctl_model.sv
// upstream controller model: clear request and register read select
`timescale 1ns/1ps
module bfsl_ctl_model
(
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic clear_out,
  output logic sel_out
);
  // idle controller: no request, code register selected
  initial
  begin
    clear_out = 1'b0;
    sel_out = 1'b0;
  end
  // level change launched just after an edge, held at least one cycle
  task set_clear(input logic v);
    @(posedge clk_in) clear_out <= v;
  endtask : set_clear
  task clear_pulse;
    set_clear(1'b1);
    set_clear(1'b0);
    #1;
  endtask : clear_pulse
  // two edges so the registered read data has caught up with the select
  task read_reg(input logic s, output logic [15:0] d);
    @(posedge clk_in) sel_out <= s;
    @(posedge clk_in);
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask : read_reg
endmodule : bfsl_ctl_model

// >>> tb/bfsl_top_tb_top.sv
// self-checking bench for the bridge fault status logic
`timescale 1ns/1ps
module bfsl_top_tb_top;
  import bfsl_pkg::*;
  localparam int BLK = 4;
  logic clk = 1'b0, srst = 1'b1, low = 1'b0, pv = 1'b0, ast = 1'b0;
  logic [2:0] pk = 3'h0;
  logic [15:0] pn = 16'h0000, rd, code, node, v;
  logic clr, sel, sdf, saf, paf, pdf, lamp, txe;
  int mismatches = 0, checks = 0;
  logic [15:0] codes [8] = '{BFSL_CODE_HW_A, BFSL_CODE_HW_B, BFSL_CODE_BAD_TARGET,
    BFSL_CODE_BAD_VALUE, BFSL_CODE_ACCESS, BFSL_CODE_SLAVE_STATUS, BFSL_CODE_DUP_ID,
    BFSL_CODE_NO_ID};
  // 25 MHz clock
  always #20 clk = ~clk;
  bfsl_ctl_model ctl (.clk_in(clk), .rdata_in(rd), .clear_out(clr), .sel_out(sel));
  // short blink count keeps the lamp test brief
  bfsl_top #(.BLINK_CYC(BLK)) dut (.CLK_IN(clk), .SRST_IN(srst), .SUPPLY_LOW_IN(low),
    .PFAULT_VALID_IN(pv), .PFAULT_KIND_IN(pk), .PFAULT_NODE_IN(pn),
    .ACCESS_START_IN(ast), .FAULT_CLEAR_REQUEST_IN(clr), .REG_SEL_IN(sel),
    .REG_RDATA_OUT(rd), .LATEST_FAULT_CODE_OUT(code), .LATEST_FAULT_NODE_OUT(node),
    .SUPPLY_DROP_FLAG_OUT(sdf), .SLAVE_ALARM_FLAG_OUT(saf),
    .PARAM_ACCESS_FAULT_FLAG_OUT(paf), .PARAM_ACCESS_DONE_FLAG_OUT(pdf),
    .ALARM_LAMP_OUT(lamp), .TX_ENABLE_OUT(txe));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // flags packed as supply, slave alarm, access fault, lamp, tx enable
  task chkf(input logic [4:0] exp);
    chk({11'h000, sdf, saf, paf, lamp, txe}, {11'h000, exp});
  endtask : chkf
  task end_sim;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  // one-cycle access error report, checked once it has been taken
  task pf(input logic [2:0] k, input logic [15:0] n);
    @(posedge clk)
    begin
      pv <= 1'b1;
      pk <= k;
      pn <= n;
    end
    @(posedge clk) pv <= 1'b0;
    #1;
  endtask : pf
  task chk_clear;
    ctl.clear_pulse();
    chk(code, 16'h0000);
    chk(node, 16'h0000);
    chk({15'h0000, sdf | saf | paf | lamp}, 16'h0000);
  endtask : chk_clear
  // watchdog: the tests need well under 200 us
  initial
  begin
    #200000;
    mismatches++;
    end_sim();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    wait_cyc(1);
    chk(code, BFSL_REG_RESET);
    chk(node, BFSL_REG_RESET);
    chkf(5'b00001);
    @(posedge clk) low <= 1'b1;
    wait_cyc(1);
    chkf(5'b10010);
    chk(code, BFSL_CODE_SUPPLY_DROP);
    chk(node, BFSL_NODE_NONE);
    wait_cyc(2);
    chk({15'h0000, lamp}, 16'h0001);
    wait_cyc(BLK);
    chk({15'h0000, lamp}, 16'h0000);
    chk({15'h0000, txe}, 16'h0000);
    @(posedge clk) low <= 1'b0;
    wait_cyc(1 + BLK);
    chk({15'h0000, txe}, 16'h0001);
    // lamp keeps blinking after the cause is gone: one interval flips it
    v = {15'h0000, lamp};
    wait_cyc(BLK);
    chk({15'h0000, lamp}, ~v & 16'h0001);
    chk({15'h0000, sdf}, 16'h0001);
    chk(node, BFSL_NODE_NONE);
    chk(code, BFSL_CODE_SUPPLY_DROP);
    chk_clear();
    // every access error kind, each followed by a clear
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk) ast <= 1'b1;
      @(posedge clk) ast <= 1'b0;
      wait_cyc(1);
      chk({15'h0000, pdf}, 16'h0000);
      pf(k[2:0], 16'h0040 + k[15:0]);
      chk(code, codes[k]);
      chk(node, (k == 2) ? BFSL_NODE_NONE : 16'h0040 + k[15:0]);
      chkf({1'b0, k != 4, k == 4, 2'b11});
      chk({15'h0000, pdf}, 16'h0001);
      ctl.read_reg(BFSL_IDX_NODE, v);
      chk(v, (k == 2) ? BFSL_NODE_NONE : 16'h0040 + k[15:0]);
      ctl.read_reg(BFSL_IDX_CODE, v);
      chk(v, codes[k]);
      chk_clear();
    end
    // supply edge and access error together, then a later error
    @(posedge clk)
    begin
      low <= 1'b1;
      pv <= 1'b1;
      pk <= 3'h0;
      pn <= 16'h0011;
    end
    @(posedge clk) pv <= 1'b0;
    #1;
    chk(code, BFSL_CODE_SUPPLY_DROP);
    @(posedge clk) low <= 1'b0;
    pf(3'h6, 16'h0077);
    chk(code, BFSL_CODE_DUP_ID);
    chk(node, 16'h0077);
    wait_cyc(BLK + 2);
    chk({15'h0000, lamp & sdf & saf}, 16'h0001);
    // clear held high acts once; a fault during the hold stays latched
    ctl.set_clear(1'b1);
    wait_cyc(2);
    chk(code, 16'h0000);
    pf(3'h3, 16'h0022);
    wait_cyc(3);
    chk(code, BFSL_CODE_BAD_VALUE);
    ctl.set_clear(1'b0);
    chk_clear();
    // a reset in mid-run drops every latched fault
    pf(3'h1, 16'h0033);
    chk(code, BFSL_CODE_HW_B);
    @(posedge clk) srst <= 1'b1;
    wait_cyc(2);
    @(posedge clk) srst <= 1'b0;
    wait_cyc(1);
    chk(code, BFSL_REG_RESET);
    chk(node, BFSL_REG_RESET);
    chkf(5'b00001);
    chk({15'h0000, pdf}, 16'h0000);
    ctl.read_reg(BFSL_IDX_NODE, v);
    chk(v, BFSL_REG_RESET);
    end_sim();
  end
endmodule : bfsl_top_tb_top
